/* fqmc_bench.sv */
// Bench for both ends of the quad-mode command link.
// Assumes design files and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module fqmc_bench import fqmc_pkg::*; ();
    logic clk, rstn, busy_in, req_valid, req_ready, rsp_valid, qe, fw, cr, dp, hq, hx;
    fqmc_op_e req_op;
    logic [23:0] req_addr;
    logic [7:0] req_data, rsp_data;
    logic [39:0] param_tab = 40'hff_5cd5a2f7;
    int num_errors, check_count, n;
    fqmc_if i_fqmc_if ();
    fqmc_host i_fqmc_host (.link(i_fqmc_if.host), .clk(clk), .rstn(rstn), .req_valid(req_valid),
        .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .qpi_on(hq), .xip_on(hx));
    fqmc_device i_fqmc_device (.link(i_fqmc_if.dev), .rstn(rstn), .busy_in(busy_in), .quad_enable_flag(qe),
        .four_wire_command_mode(fw), .continuous_read(cr), .deep_power_down(dp));
    fqmc_sva i_fqmc_sva (.clk(clk), .rstn(rstn), .sck(i_fqmc_if.sck), .cs_n(i_fqmc_if.cs_n),
        .host_dq_o(i_fqmc_if.host_dq_o), .host_dq_oe(i_fqmc_if.host_dq_oe), .dev_dq_o(i_fqmc_if.dev_dq_o),
        .dev_dq_oe(i_fqmc_if.dev_dq_oe), .dq(i_fqmc_if.dq));
    // Clock of 50 ns.
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // Host ready, host mode and device mode flags packed as one byte.
    function automatic logic [7:0] flags();
        return {1'b0, req_ready, hq, hx, qe, fw, cr, dp};
    endfunction
    // Compares a value seen with the value expected.
    task chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %0t: %h not %h", $time, s, e);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task tally_and_finish;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Issues one operation and waits for its completion pulse.
    task run(input fqmc_op_e o, input logic [7:0] d, input logic [23:0] a);
        @(negedge clk);
        req_op = o;
        req_data = d;
        req_addr = a;
        req_valid = 1;
        @(negedge clk);
        req_valid = 0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        chk({7'h0, rsp_valid}, 8'h01);
    endtask
    // Stops a hung run.
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        tally_and_finish;
    end
    // Main sequence.
    initial begin
        rstn = 0;
        busy_in = 1;
        req_valid = 0;
        req_op = OP_RDSR1;
        req_addr = 24'h0;
        req_data = 8'h0;
        repeat (16) @(negedge clk);
        rstn = 1;
        chk(flags(), 8'h40);
        run(OP_RDSR1, 8'h0, 24'h0);
        chk({7'h0, rsp_data[0]}, 8'h01);
        fork
            run(OP_POLL, 8'h0, 24'h0);
            begin
                repeat (200) @(negedge clk);
                busy_in = 0;
            end
        join
        chk({7'h0, rsp_data[0]}, 8'h00);
        chk({7'h0, n > 190}, 8'h01);
        run(OP_QREAD, 8'ha5, 24'h0);
        chk(rsp_data, 8'hff);
        run(OP_WRSR, 8'h02, 24'h0);
        run(OP_RDSR2, 8'h0, 24'h0);
        chk({6'h0, rsp_data[1], qe}, 8'h03);
        run(OP_QREAD, 8'ha5, 24'h12);
        chk(flags(), 8'h5a);
        run(OP_QREAD, 8'h00, 24'h12);
        chk(flags(), 8'h48);
        run(OP_QREAD, 8'ha0, 24'h0);
        chk(flags(), 8'h5a);
        run(OP_MBR, 8'h0, 24'h0);
        chk(flags(), 8'h48);
        run(OP_QPI_ON, 8'h0, 24'h0);
        chk(flags(), 8'h6c);
        run(OP_RDSR2, 8'h0, 24'h0);
        chk(rsp_data, 8'h02);
        run(OP_QPI_OFF, 8'h0, 24'h0);
        chk(flags(), 8'h48);
        for (int i = 0; i < 5; i++) begin
            run(OP_PARAM, 8'h0, (i < 4) ? 24'h34 + 24'(i) : 24'h3c);
            chk(rsp_data, param_tab[8*i+:8]);
        end
        run(OP_PARAM, 8'h0, 24'h3a);
        chk({7'h0, rsp_data[7]}, 8'h00);
        run(OP_DPD, 8'h0, 24'h0);
        chk(flags(), 8'h49);
        run(OP_WAKE, 8'h0, 24'h0);
        chk(flags(), 8'h48);
        chk({7'h0, n >= 60}, 8'h01);
        run(OP_WRSR, 8'h00, 24'h0);
        chk(flags(), 8'h40);
        tally_and_finish;
    end
endmodule
`default_nettype wire

/* fqmc_defines.svh */
// Constants shared by both ends of the quad-mode command link.
// Assumes it is included by bare name from the host and device files.
`ifndef FQMC_DEFINES_SVH
`define FQMC_DEFINES_SVH

// Instruction codes.
`define FQMC_CMD_RDSR1 8'h05
`define FQMC_CMD_RDSR2 8'h35
`define FQMC_CMD_WRSR 8'h01
`define FQMC_CMD_QPI_ON 8'h38
`define FQMC_CMD_QPI_OFF 8'hf5
`define FQMC_CMD_DPD 8'hb9
`define FQMC_CMD_WAKE 8'hab
`define FQMC_CMD_QREAD 8'heb
`define FQMC_CMD_PARAM 8'h5a

// Status bit positions.
`define FQMC_BUSY_BIT 0
`define FQMC_QE_BIT 1

// Continuous read mode byte and mode-bit reset.
`define FQMC_MODE_NIB 4'ha
`define FQMC_MBR_NIB 4'hf
`define FQMC_MBR_CLKS 4'd8
`define FQMC_DUMMY_CLKS 4'd8

// Parameter table: two double-words from relative address 34h.
`define FQMC_PARAM_BASE 8'h34
`define FQMC_PARAM_DW14 32'h5cd5a2f7
`define FQMC_PARAM_DW15 32'hff5df622

// Timing in the host clock domain.
`define FQMC_CLK_NS 50
`define FQMC_WAKE_NS 3000
`define FQMC_WAKE_CYC ((`FQMC_WAKE_NS + `FQMC_CLK_NS - 1) / `FQMC_CLK_NS)
`define FQMC_GAP_CYC 4

`endif

/* fqmc_device.sv */
// Flash device end: command decoder on the serial link clock.
// Assumes the host drives sck and cs_n; cs_n high clears all frame state.
`include "fqmc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fqmc_device import fqmc_pkg::*; (
    fqmc_if.dev link, // Serial link.
    input wire logic rstn, // Power-on reset, active low.
    input wire logic busy_in, // Internal operation in progress.
    output logic quad_enable_flag, // Quad enable state.
    output logic four_wire_command_mode, // Four-wire command mode active.
    output logic continuous_read, // Continuous quad read armed.
    output logic deep_power_down // Deep power down active.
);
    // ************************************************************
    // Signals
    // ************************************************************
    logic frame_rst_n;
    logic busy_s;
    fqmc_dph_e ph_q, ph_d, cur_ph;
    logic [3:0] cnt_q, cnt_d;
    logic [1:0] bcnt_q, bcnt_d;
    logic [7:0] sh_q, byte_in, cmd_q, cmd_d, addr_q, addr_d, out_q, out_d;
    logic [3:0] ones_q;
    logic [3:0] dq_o_q, dq_oe_q;
    logic qe_q, xip_q, qpi_q, dpd_q;
    logic quad_body, w4, done, dummy_done, cmd_done;
    logic [7:0] sr1, sr2;

    // Frame state is cleared whenever the device is deselected.
    assign frame_rst_n = rstn & ~link.cs_n;

    fqmc_sync #(.WIDTH(1)) u_busy_sync (
        .clk(link.sck),
        .rstn(rstn),
        .d(busy_in),
        .q(busy_s)
    );

    // ************************************************************
    // Parameter table lookup
    // ************************************************************
    // Returns one byte of the two double-words, least significant first.
    function automatic logic [7:0] param_byte(input logic [7:0] a);
        logic [7:0] idx;
        logic [63:0] tbl;
        idx = a - `FQMC_PARAM_BASE;
        tbl = {`FQMC_PARAM_DW15, `FQMC_PARAM_DW14};
        param_byte = (idx < 8'h08) ? 8'(tbl >> {idx[2:0], 3'b000}) : 8'hff;
    endfunction

    // ************************************************************
    // Input shifting and phase decode
    // ************************************************************
    // busy in bit 0.
    assign sr1 = 8'(busy_s) << `FQMC_BUSY_BIT;
    assign sr2 = 8'(qe_q) << `FQMC_QE_BIT;

    // An idle frame opens with address nibbles when continuous read is armed.
    assign cur_ph = (ph_q == DP_IDLE) ? (xip_q ? DP_ADDR : DP_CMD) : ph_q;
    assign quad_body = (ph_q == DP_IDLE) ? xip_q : (cmd_q == `FQMC_CMD_QREAD);
    assign w4 = qpi_q | (quad_body & (cur_ph != DP_CMD));
    assign byte_in = w4 ? {sh_q[3:0], link.dq} : {sh_q[6:0], link.dq[0]};
    assign done = (cnt_q == (w4 ? 4'd1 : 4'd7));
    assign dummy_done = (cnt_q == `FQMC_DUMMY_CLKS - 4'd1);
    assign cmd_done = (cur_ph == DP_CMD) & done;

    // Next phase, counters and output byte.
    always_comb begin
        ph_d = cur_ph;
        cnt_d = done ? 4'd0 : 4'(cnt_q + 4'd1);
        bcnt_d = bcnt_q;
        cmd_d = (ph_q == DP_IDLE && xip_q) ? `FQMC_CMD_QREAD : cmd_q;
        addr_d = addr_q;
        out_d = w4 ? {out_q[3:0], 4'h0} : {out_q[6:0], 1'b0};
        case (cur_ph)
            DP_CMD: begin
                if (done) begin
                    cmd_d = byte_in;
                    ph_d = DP_SKIP;
                    if (!dpd_q) begin
                        case (byte_in)
                            `FQMC_CMD_RDSR1: begin
                                out_d = sr1;
                                ph_d = DP_OUT;
                            end
                            `FQMC_CMD_RDSR2: begin
                                out_d = sr2;
                                ph_d = DP_OUT;
                            end
                            `FQMC_CMD_WRSR: ph_d = DP_WR;
                            `FQMC_CMD_QREAD: ph_d = qe_q ? DP_ADDR : DP_SKIP;
                            `FQMC_CMD_PARAM: ph_d = DP_ADDR;
                            default: ph_d = DP_SKIP;
                        endcase
                    end
                end
            end
            DP_ADDR: begin
                if (done) begin
                    addr_d = byte_in;
                    bcnt_d = 2'(bcnt_q + 2'd1);
                    if (bcnt_q == 2'd2) begin
                        bcnt_d = 2'd0;
                        ph_d = quad_body ? DP_MODE : DP_DUMMY;
                    end
                end
            end
            DP_MODE: ph_d = done ? DP_SKIP : cur_ph;
            DP_DUMMY: begin
                cnt_d = dummy_done ? 4'd0 : 4'(cnt_q + 4'd1);
                if (dummy_done) begin
                    out_d = param_byte(addr_q);
                    addr_d = 8'(addr_q + 8'd1);
                    ph_d = DP_OUT;
                end
            end
            DP_OUT: begin
                if (done) begin
                    if (cmd_q == `FQMC_CMD_PARAM) begin
                        out_d = param_byte(addr_q);
                        addr_d = 8'(addr_q + 8'd1);
                    end else begin
                        out_d = (cmd_q == `FQMC_CMD_RDSR2) ? sr2 : sr1;
                    end
                end
            end
            DP_WR: begin
                if (done) begin
                    bcnt_d = 2'(bcnt_q + 2'd1);
                    if (bcnt_q == 2'd1) begin
                        ph_d = DP_SKIP;
                    end
                end
            end
            default: ph_d = cur_ph;
        endcase
    end

    // ************************************************************
    // Frame registers
    // ************************************************************
    // Frame state, cleared by deselect; outputs turn off with it.
    always_ff @(posedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            ph_q <= DP_IDLE;
            cnt_q <= 4'h0;
            bcnt_q <= 2'h0;
            sh_q <= 8'h00;
            cmd_q <= 8'h00;
            addr_q <= 8'h00;
            out_q <= 8'h00;
        end else begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            bcnt_q <= bcnt_d;
            sh_q <= byte_in;
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            out_q <= out_d;
        end
    end

    // Output lines change on the falling clock, after the host has let go of them.
    always_ff @(negedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            dq_o_q <= 4'h0;
            dq_oe_q <= 4'h0;
        end else begin
            dq_o_q <= qpi_q ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
            dq_oe_q <= (ph_q != DP_OUT) ? 4'h0 : (qpi_q ? 4'hf : 4'h2);
        end
    end

    // Counts all-ones clocks from frame start; 4'hf marks a broken run.
    always_ff @(posedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            ones_q <= 4'h0;
        end else if (ones_q != 4'hf) begin
            if (link.dq != `FQMC_MBR_NIB) begin
                ones_q <= 4'hf;
            end else if (ones_q != `FQMC_MBR_CLKS) begin
                ones_q <= 4'(ones_q + 4'd1);
            end
        end
    end

    // ************************************************************
    // Persistent mode state
    // ************************************************************
    // power down entry and exit.
    always_ff @(posedge link.sck or negedge rstn) begin
        if (!rstn) begin
            dpd_q <= 1'b0;
        end else if (cmd_done) begin
            if (dpd_q && byte_in == `FQMC_CMD_WAKE) begin
                dpd_q <= 1'b0;
            end else if (!dpd_q && byte_in == `FQMC_CMD_DPD) begin
                dpd_q <= 1'b1;
            end
        end
    end

    // Four-wire command mode follows 38h and F5h.
    always_ff @(posedge link.sck or negedge rstn) begin
        if (!rstn) begin
            qpi_q <= 1'b0;
        end else if (cmd_done && !dpd_q) begin
            if (byte_in == `FQMC_CMD_QPI_ON) begin
                qpi_q <= 1'b1;
            end else if (byte_in == `FQMC_CMD_QPI_OFF) begin
                qpi_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge link.sck or negedge rstn) begin
        if (!rstn) begin
            qe_q <= 1'b0;
        end else if (cur_ph == DP_WR && done && bcnt_q == 2'd1) begin
            qe_q <= byte_in[`FQMC_QE_BIT];
        end
    end

    // Continuous read arms on the mode byte and drops on a mode-bit reset.
    always_ff @(posedge link.sck or negedge rstn) begin
        if (!rstn) begin
            xip_q <= 1'b0;
        end else if (ones_q == `FQMC_MBR_CLKS - 4'd1 && link.dq == `FQMC_MBR_NIB) begin
            xip_q <= 1'b0;
        end else if (cur_ph == DP_MODE && done) begin
            xip_q <= (byte_in[7:4] == `FQMC_MODE_NIB);
        end
    end

    assign link.dev_dq_o = dq_o_q;
    assign link.dev_dq_oe = dq_oe_q;
    assign quad_enable_flag = qe_q;
    assign four_wire_command_mode = qpi_q;
    assign continuous_read = xip_q;
    assign deep_power_down = dpd_q;
endmodule
`default_nettype wire

/* fqmc_host.sv */
// Host controller end: turns operation requests into link frames.
// Assumes a device on the link that samples on the rising sck edge.
`include "fqmc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fqmc_host import fqmc_pkg::*; #(
    parameter int HALF = 2
) (
    fqmc_if.host link, // Serial link.
    input wire logic clk, // System clock.
    input wire logic rstn, // Async reset, active low.
    input wire logic req_valid, // Request strobe.
    input wire fqmc_op_e req_op, // Requested operation.
    input wire logic [23:0] req_addr, // Read address.
    input wire logic [7:0] req_data, // Mode byte or quad enable value.
    output logic req_ready, // Idle, request accepted.
    output logic rsp_valid, // Completion pulse.
    output logic [7:0] rsp_data, // Last byte received.
    output logic qpi_on, // Host believes four-wire mode is on.
    output logic xip_on // Host believes continuous read is armed.
);
    fqmc_hst_e st_q;
    fqmc_op_e op_q, sel_op;
    logic [7:0] data_q, rx_q, s_cmd, div_q;
    logic [47:0] tx_q, s_tx, tx_sh;
    logic [5:0] k_q, k_n, cc_q, txe_q, rxs_q, tot_q, s_cc, s_txe, s_rxs, s_tot, s_bpc, s_rx;
    logic [15:0] gap_q;
    logic [3:0] din_s, dq_o_q, dq_oe_q;
    logic sck_q, cs_q, wq_q, s_wq, qe_q, qpi_q, xip_q, w_k, w_n, load, refuse, tick;

    fqmc_sync #(.WIDTH(4)) u_dq_sync (
        .clk(clk),
        .rstn(rstn),
        .d(link.dq),
        .q(din_s)
    );

    // ************************************************************
    // Frame setup
    // ************************************************************
    // Builds the bit stream and clock counts for one frame.
    assign sel_op = (st_q == HS_IDLE) ? req_op : op_q;
    always_comb begin
        s_wq = (sel_op == OP_QREAD) | (sel_op == OP_MBR);
        s_bpc = (qpi_q | s_wq) ? 6'd2 : 6'd8;
        s_rx = qpi_q ? 6'd2 : 6'd8;
        s_cc = qpi_q ? 6'd2 : 6'd8;
        case (sel_op)
            OP_RDSR1, OP_POLL: s_cmd = `FQMC_CMD_RDSR1;
            OP_RDSR2: s_cmd = `FQMC_CMD_RDSR2;
            OP_WRSR: s_cmd = `FQMC_CMD_WRSR;
            OP_DPD: s_cmd = `FQMC_CMD_DPD;
            OP_WAKE: s_cmd = `FQMC_CMD_WAKE;
            OP_QPI_ON: s_cmd = `FQMC_CMD_QPI_ON;
            OP_QPI_OFF: s_cmd = `FQMC_CMD_QPI_OFF;
            OP_QREAD: s_cmd = `FQMC_CMD_QREAD;
            OP_PARAM: s_cmd = `FQMC_CMD_PARAM;
            default: s_cmd = 8'h00;
        endcase
        s_tx = {s_cmd, 40'h0};
        s_txe = s_cc;
        s_rxs = s_cc;
        s_tot = s_cc;
        case (sel_op)
            OP_RDSR1, OP_RDSR2, OP_POLL: s_tot = 6'(s_cc + s_rx);
            OP_WRSR: begin
                s_tx = {s_cmd, 8'h00, 8'(req_data[`FQMC_QE_BIT]) << `FQMC_QE_BIT, 24'h0};
                s_txe = 6'(s_cc + 6'(2 * s_bpc));
                s_tot = s_txe;
                s_rxs = s_txe;
            end
            OP_QREAD: begin
                s_cc = xip_q ? 6'd0 : s_cc;
                s_tx = xip_q ? {req_addr, req_data, 16'h0} : {s_cmd, req_addr, req_data, 8'h0};
                s_txe = 6'(s_cc + 6'd8);
                s_tot = s_txe;
                s_rxs = s_txe;
            end
            OP_PARAM: begin
                s_tx = {s_cmd, req_addr, 16'h0};
                s_txe = 6'(s_cc + 6'(3 * s_bpc));
                s_rxs = 6'(s_txe + 6'(`FQMC_DUMMY_CLKS));
                s_tot = 6'(s_rxs + s_rx);
            end
            OP_MBR: begin
                s_cc = 6'd0;
                s_tx = 48'hffffffffffff;
                s_txe = 6'(`FQMC_MBR_CLKS);
                s_tot = s_txe;
                s_rxs = s_txe;
            end
            default: s_tot = s_cc;
        endcase
    end

    // Width of the current and the next clock, and the shifted stream.
    assign k_n = 6'(k_q + 6'd1);
    assign w_k = qpi_q | (wq_q & (k_q >= cc_q));
    assign w_n = qpi_q | (wq_q & (k_n >= cc_q));
    assign tx_sh = w_k ? {tx_q[43:0], 4'h0} : {tx_q[46:0], 1'b0};
    assign refuse = (req_op == OP_QREAD) & ~qe_q;
    assign load = ((st_q == HS_IDLE) & req_valid & ~refuse) |
                  ((st_q == HS_GAP) & (gap_q == 16'h0) & (op_q == OP_POLL) & rx_q[`FQMC_BUSY_BIT]);
    assign tick = (div_q == 8'(HALF - 1));

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    // Drives sck, chip select and data; samples answers on each fall.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= HS_IDLE;
            op_q <= OP_RDSR1;
            data_q <= 8'h00;
            tx_q <= 48'h0;
            {k_q, cc_q, txe_q, rxs_q, tot_q} <= 30'h0;
            wq_q <= 1'b0;
            div_q <= 8'h00;
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            dq_o_q <= 4'h0;
            dq_oe_q <= 4'h0;
            rx_q <= 8'h00;
            gap_q <= 16'h0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            if (load) begin
                st_q <= HS_RUN;
                op_q <= sel_op;
                data_q <= (st_q == HS_IDLE) ? req_data : data_q;
                tx_q <= s_tx;
                {k_q, cc_q, txe_q, rxs_q, tot_q} <= {6'd0, s_cc, s_txe, s_rxs, s_tot};
                wq_q <= s_wq;
                div_q <= 8'h00;
                sck_q <= 1'b0;
                cs_q <= 1'b0;
                dq_o_q <= (qpi_q | (s_wq & s_cc == 6'd0)) ? s_tx[47:44] : {3'b000, s_tx[47]};
                dq_oe_q <= (qpi_q | (s_wq & s_cc == 6'd0)) ? 4'hf : 4'h1;
            end else if (st_q == HS_IDLE && req_valid) begin
                rsp_valid <= 1'b1;
                rsp_data <= 8'hff;
            end else if (st_q == HS_RUN) begin
                div_q <= tick ? 8'h00 : 8'(div_q + 8'd1);
                if (tick && !sck_q) begin
                    sck_q <= 1'b1;
                end else if (tick) begin
                    sck_q <= 1'b0;
                    // Device data changes on a fall, so the synced copy is taken one fall later.
                    if (k_q >= rxs_q) begin
                        rx_q <= qpi_q ? {rx_q[3:0], din_s} : {rx_q[6:0], din_s[1]};
                    end
                    if (k_n == tot_q) begin
                        st_q <= HS_GAP;
                        cs_q <= 1'b1;
                        dq_oe_q <= 4'h0;
                        gap_q <= (op_q == OP_WAKE) ? 16'(`FQMC_WAKE_CYC - 1) : 16'(`FQMC_GAP_CYC - 1);
                    end else begin
                        k_q <= k_n;
                        tx_q <= tx_sh;
                        dq_o_q <= w_n ? tx_sh[47:44] : {3'b000, tx_sh[47]};
                        dq_oe_q <= (k_n >= txe_q) ? 4'h0 : (w_n ? 4'hf : 4'h1);
                    end
                end
            end else if (st_q == HS_GAP) begin
                gap_q <= 16'(gap_q - 16'd1);
                if (gap_q == 16'h0) begin
                    st_q <= HS_IDLE;
                    rsp_valid <= 1'b1;
                    rsp_data <= rx_q;
                end
            end
        end
    end

    // Tracks quad enable, four-wire mode and continuous read from completed frames.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            qe_q <= 1'b0;
            qpi_q <= 1'b0;
            xip_q <= 1'b0;
        end else if (st_q == HS_GAP && gap_q == 16'h0) begin
            case (op_q)
                OP_WRSR: qe_q <= data_q[`FQMC_QE_BIT];
                OP_QPI_ON: qpi_q <= 1'b1;
                OP_QPI_OFF: qpi_q <= 1'b0;
                OP_QREAD: xip_q <= (data_q[7:4] == `FQMC_MODE_NIB);
                OP_MBR: xip_q <= 1'b0;
                default: qe_q <= qe_q;
            endcase
        end
    end

    assign req_ready = st_q[0]; // Idle is the lowest one-hot bit.
    assign qpi_on = qpi_q;
    assign xip_on = xip_q;
    assign link.sck = sck_q;
    assign link.cs_n = cs_q;
    assign link.host_dq_o = dq_o_q;
    assign link.host_dq_oe = dq_oe_q;
endmodule
`default_nettype wire

/* fqmc_if.sv */
// Link between host controller and flash device.
// Assumes one host and one device; undriven lines read high (pull-up).
`timescale 1ns/1ps
`default_nettype none
interface fqmc_if;
    logic sck;
    logic cs_n;
    logic [3:0] host_dq_o;
    logic [3:0] host_dq_oe;
    logic [3:0] dev_dq_o;
    logic [3:0] dev_dq_oe;
    logic [3:0] dq;

    // Resolve the shared quad data lines from both enables.
    assign dq = (host_dq_oe & host_dq_o) | (~host_dq_oe & dev_dq_oe & dev_dq_o) | (~host_dq_oe & ~dev_dq_oe);

    modport dev (input sck, input cs_n, input dq, output dev_dq_o, output dev_dq_oe);
    modport host (output sck, output cs_n, output host_dq_o, output host_dq_oe, input dq);
endinterface
`default_nettype wire

/* fqmc_pkg.sv */
// Types shared by both ends of the quad-mode command link.
// Assumes nothing beyond a SystemVerilog compiler.
package fqmc_pkg;

    // Device frame phases, one-hot.
    typedef enum logic [7:0] {
        DP_IDLE = 8'h01,
        DP_CMD = 8'h02,
        DP_ADDR = 8'h04,
        DP_MODE = 8'h08,
        DP_DUMMY = 8'h10,
        DP_OUT = 8'h20,
        DP_WR = 8'h40,
        DP_SKIP = 8'h80
    } fqmc_dph_e;

    // Host controller states, one-hot.
    typedef enum logic [2:0] {
        HS_IDLE = 3'h1,
        HS_RUN = 3'h2,
        HS_GAP = 3'h4
    } fqmc_hst_e;

    // Host operations.
    typedef enum logic [3:0] {
        OP_RDSR1 = 4'h0,
        OP_RDSR2 = 4'h1,
        OP_POLL = 4'h2,
        OP_WRSR = 4'h3,
        OP_DPD = 4'h4,
        OP_WAKE = 4'h5,
        OP_QPI_ON = 4'h6,
        OP_QPI_OFF = 4'h7,
        OP_QREAD = 4'h8,
        OP_MBR = 4'h9,
        OP_PARAM = 4'ha
    } fqmc_op_e;

endpackage

/* fqmc_sva.sv */
// Wire checks for the quad-mode command link.
// Assumes the host clock and reset drive it.
`timescale 1ns/1ps
`default_nettype none
module fqmc_sva (
    input wire logic clk, // Host clock.
    input wire logic rstn, // Reset, active low.
    input wire logic sck, // Serial clock.
    input wire logic cs_n, // Chip select.
    input wire logic [3:0] host_dq_o, // Host data.
    input wire logic [3:0] host_dq_oe, // Host enable.
    input wire logic [3:0] dev_dq_o, // Device data.
    input wire logic [3:0] dev_dq_oe, // Device enable.
    input wire logic [3:0] dq // Resolved lines.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ****
    // Checks
    // ****
    // Turnaround, idle levels and clock shape.
    a_no_clash: assert property ((host_dq_oe & dev_dq_oe) == 4'h0)
        else $error("both ends drive");
    a_idle_release: assert property (cs_n |-> dev_dq_oe == 4'h0)
        else $error("device drives while idle");
    a_sck_idle: assert property (cs_n |-> !sck)
        else $error("clock runs while idle");
    a_pull_up: assert property ((host_dq_oe | dev_dq_oe) == 4'h0 |-> dq == 4'hf)
        else $error("released lines not high");
    a_host_level: assert property (((dq ^ host_dq_o) & host_dq_oe) == 4'h0)
        else $error("host level lost");
    a_dev_level: assert property (((dq ^ dev_dq_o) & dev_dq_oe) == 4'h0)
        else $error("device level lost");
    a_sck_half: assert property ($rose(sck) |=> sck)
        else $error("clock high too short");
    a_frame_start: assert property ($fell(cs_n) |=> !sck)
        else $error("frame starts on high clock");
    cover property ($fell(cs_n));
    cover property (dev_dq_oe == 4'hf);
    cover property (host_dq_oe == 4'hf);
endmodule
`default_nettype wire

/* fqmc_sync.sv */
// Two-stage level synchroniser.
// Assumes the input is a level that stays stable for several clocks.
`timescale 1ns/1ps
`default_nettype none
module fqmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // Sampling clock.
    input wire logic rstn, // Async reset, active low.
    input wire logic [WIDTH-1:0] d, // Level from another domain.
    output logic [WIDTH-1:0] q // Synchronised level.
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire
